// ===== hdl/rx_path_cfg_pkg.sv
/*
  Constants of the receive-path configuration bank: register indices, field
  positions, reset values and the channel filter bandwidth base.
  Assumes a Wishbone word bus where byte address = 4 x register index.
*/
package rx_path_cfg_pkg;

  localparam logic [5:0] FCC_INDEX    = 6'h0F;
  localparam logic [5:0] FILT_INDEX   = 6'h10;

  localparam int         SETTLE_HI    = 7;
  localparam int         SETTLE_LO    = 6;
  localparam int         DEVX_HI      = 5;
  localparam int         DEVX_LO      = 4;
  localparam int         DEVM_HI      = 3;
  localparam int         DEVM_LO      = 0;
  localparam int         BYPASS_BIT   = 7;
  localparam int         SHIFT_HI     = 6;
  localparam int         SHIFT_LO     = 5;
  localparam int         DIV_HI       = 4;
  localparam int         DIV_LO       = 0;

  // Settling 2, exponent 1, mantissa 12.
  localparam logic [7:0] FCC_RESET    = 8'h9C;
  localparam logic [7:0] FILT_RESET   = 8'h00;

  // Bandwidth is reported in units of 0.1 Hz; 307.2 kHz is the base.
  localparam int         BW_BASE_DHZ  = 3072000;
  localparam int         BW_WIDTH     = 22;

endpackage : rx_path_cfg_pkg

// ===== hdl/rx_path_cfg.sv
/*
  Receive-path configuration bank: frequency correction control and channel
  filter control registers behind a classic Wishbone slave, plus the logic they
  steer: the frequency offset averager, the decimation clock divider, the
  expected deviation and the channel filter bandwidth.
  The bus answers every request with a single-cycle ack one cycle after it is
  taken; writes land at the ack edge and read data stands in the ack cycle.
  Unmapped indices are acked, read as zero and ignore writes.
  Derived outputs (averaging length, scaled deviation, divisor, bandwidth)
  follow the registers one cycle later, so they never glitch on a write.
  Assumes pair_strobe_i and freq_est_i come from the demodulator on clk_i.
  Assumes the bus master holds its request until it sees ack and then drops
  cyc and stb for at least one cycle before the next request.
  Assumes the demodulator never presents more than one estimate per strobe.
  A user must know that a frequency control write discards a partial average,
  so the next average starts from a clean sum after the write.
  The bandwidth table trades a little area for a division-free output path.
*/
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
module rx_path_cfg
  import rx_path_cfg_pkg::*;
#(
  parameter int EST_WIDTH = 12
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [7:0]                  adr_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic [31:0]                 dat_i,
  output logic      [31:0]                 dat_o,
  output logic                             ack_o,
  input  wire logic                        pair_strobe_i,
  input  wire logic signed [EST_WIDTH-1:0] freq_est_i,
  output logic                             afc_enable_o,
  output logic      [2:0]                  avg_pairs_o,
  output logic signed [EST_WIDTH-1:0]      freq_offset_o,
  output logic                             freq_offset_valid_o,
  output logic      [1:0]                  rx_dev_exponent_o,
  output logic      [3:0]                  rx_dev_mantissa_o,
  output logic      [6:0]                  rx_dev_scaled_o,
  output logic                             filter_bypass_o,
  output logic      [1:0]                  decimator_input_shift_o,
  output logic      [5:0]                  decimation_divisor_o,
  output logic                             dec_clk_tick_o,
  output logic      [BW_WIDTH-1:0]         channel_bw_o
);

  typedef struct packed {
    logic [7:0]                   fcc;
    logic [7:0]                   filt;
    logic                         ack;
    logic [31:0]                  rdat;
    logic signed [EST_WIDTH+1:0]  acc;
    logic [1:0]                   pair_cnt;
    logic signed [EST_WIDTH-1:0]  avg;
    logic                         avg_valid;
    logic                         afc_en;
    logic [2:0]                   pairs;
    logic [6:0]                   dev_scaled;
    logic [4:0]                   div_cnt;
    logic [5:0]                   divisor;
    logic                         tick;
    logic [BW_WIDTH-1:0]          bw;
  } state_t;

  state_t s;
  state_t next_s;

  // Bandwidth per divisor setting, built at elaboration.
  logic [BW_WIDTH-1:0] bw_rom [32];
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_bw
      assign bw_rom[g] = BW_WIDTH'(BW_BASE_DHZ / (g + 1));
    end
  endgenerate

  logic                        req;
  logic [5:0]                  idx;
  logic [1:0]                  settle;
  logic signed [EST_WIDTH+1:0] sum;
  logic [1:0]                  last_pair;

  assign req       = cyc_i & stb_i;
  assign idx       = adr_i[7:2];
  assign settle    = s.fcc[SETTLE_HI:SETTLE_LO];
  assign sum       = s.acc + EST_WIDTH'(0) + {{2{freq_est_i[EST_WIDTH-1]}}, freq_est_i};
  assign last_pair = (settle == 2'h3) ? 2'h3 : ((settle == 2'h2) ? 2'h1 : 2'h0);

  always_comb begin
    next_s           = s;
    next_s.avg_valid = 1'b0;
    // Ack rises one cycle after the request and drops after one cycle.
    next_s.ack       = req & ~s.ack;
    if (req && !s.ack) begin
      case (idx)
        FCC_INDEX:  next_s.rdat = {24'h000000, s.fcc};
        FILT_INDEX: next_s.rdat = {24'h000000, s.filt};
        default:    next_s.rdat = 32'h00000000;
      endcase
    end
    // Writes land at the edge where the master samples ack.
    if (req && s.ack && we_i && sel_i[0]) begin
      case (idx)
        FCC_INDEX: begin
          next_s.fcc      = dat_i[7:0];
          // A new setting restarts averaging so no stale partial sum leaks out.
          next_s.acc      = '0;
          next_s.pair_cnt = 2'h0;
        end
        FILT_INDEX: begin
          next_s.filt = dat_i[7:0];
        end
        default: begin
          next_s.rdat = s.rdat;
        end
      endcase
    end

    // Frequency offset averaging.
    next_s.afc_en = (settle != 2'h0);
    case (settle)
      2'h1:    next_s.pairs = 3'h1;
      2'h2:    next_s.pairs = 3'h2;
      2'h3:    next_s.pairs = 3'h4;
      default: next_s.pairs = 3'h0;
    endcase
    if (settle == 2'h0) begin
      next_s.acc      = '0;
      next_s.pair_cnt = 2'h0;
      next_s.avg      = '0;
    end else if (pair_strobe_i && !(req && s.ack && we_i && sel_i[0] && idx == FCC_INDEX)) begin
      if (s.pair_cnt >= last_pair) begin
        next_s.avg       = EST_WIDTH'(sum >>> (settle - 2'h1));
        next_s.avg_valid = 1'b1;
        next_s.acc       = '0;
        next_s.pair_cnt  = 2'h0;
      end else begin
        next_s.acc      = sum;
        next_s.pair_cnt = s.pair_cnt + 2'h1;
      end
    end

    // Expected deviation in units of baud/24: mantissa x 2^exponent.
    next_s.dev_scaled = 7'({3'h0, s.fcc[DEVM_HI:DEVM_LO]} << s.fcc[DEVX_HI:DEVX_LO]);

    // Decimation clock: one tick every divisor cycles.
    next_s.divisor = {1'b0, s.filt[DIV_HI:DIV_LO]} + 6'h01;
    if (s.div_cnt >= s.filt[DIV_HI:DIV_LO]) begin
      next_s.div_cnt = 5'h00;
      next_s.tick    = 1'b1;
    end else begin
      next_s.div_cnt = s.div_cnt + 5'h01;
      next_s.tick    = 1'b0;
    end
    next_s.bw = bw_rom[s.filt[DIV_HI:DIV_LO]];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s      <= '0;
      s.fcc  <= FCC_RESET;
      s.filt <= FILT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign dat_o                   = s.rdat;
  assign ack_o                   = s.ack;
  assign afc_enable_o            = s.afc_en;
  assign avg_pairs_o             = s.pairs;
  assign freq_offset_o           = s.avg;
  assign freq_offset_valid_o     = s.avg_valid;
  assign rx_dev_exponent_o       = s.fcc[DEVX_HI:DEVX_LO];
  assign rx_dev_mantissa_o       = s.fcc[DEVM_HI:DEVM_LO];
  assign rx_dev_scaled_o         = s.dev_scaled;
  assign filter_bypass_o         = s.filt[BYPASS_BIT];
  assign decimator_input_shift_o = s.filt[SHIFT_HI:SHIFT_LO];
  assign decimation_divisor_o    = s.divisor;
  assign dec_clk_tick_o          = s.tick;
  assign channel_bw_o            = s.bw;

  // Helper counters for the checks below.
  logic [5:0] tick_gap;
  logic [5:0] div_age;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_gap <= 6'h00;
      div_age  <= 6'h00;
    end else begin
      tick_gap <= s.tick ? 6'h00 : tick_gap + 6'h01;
      if (next_s.filt[DIV_HI:DIV_LO] != s.filt[DIV_HI:DIV_LO]) begin
        div_age <= 6'h00;
      end else if (div_age != 6'h3F) begin
        div_age <= div_age + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Register image and bus handshake.
  reset_values_a: assert property (
      $past(rst_i)
      |-> s.fcc == FCC_RESET)
    else $error("Frequency control reset value wrong.");

  reset_filter_a: assert property (
      $past(rst_i)
      |-> s.filt == FILT_RESET)
    else $error("Filter reset value wrong.");

  ack_follows_a: assert property (
      req && !ack_o
      |=> ack_o)
    else $error("Request not answered in one cycle.");

  ack_pulse_a: assert property (
      ack_o
      |=> !ack_o)
    else $error("Ack held longer than one cycle.");

  no_stray_ack_a: assert property (
      !req
      |=> !ack_o)
    else $error("Ack without a request.");

  // Read data stands with ack and shows the register as it was when taken.
  fcc_read_a: assert property (
      ack_o && !we_i && idx == FCC_INDEX
      |-> dat_o == {24'h000000, s.fcc})
    else $error("Frequency control readback wrong.");

  read_back_a: assert property (
      ack_o && !we_i && idx == FILT_INDEX
      |-> dat_o == {24'h000000, s.filt} ##1 !ack_o)
    else $error("Filter readback or ack drop wrong.");

  unmapped_read_a: assert property (
      ack_o && !we_i && idx != FCC_INDEX && idx != FILT_INDEX
      |-> dat_o == 32'h00000000)
    else $error("Unmapped read not zero.");

  // Writes land at the ack edge only.
  write_fcc_a: assert property (
      ack_o && req && we_i && sel_i[0] && idx == FCC_INDEX
      |=> s.fcc == $past(dat_i[7:0]))
    else $error("Frequency control write lost.");

  filt_write_a: assert property (
      ack_o && req && we_i && sel_i[0] && idx == FILT_INDEX
      |=> s.filt == $past(dat_i[7:0]))
    else $error("Filter write lost.");

  unmapped_write_a: assert property (
      ack_o && req && we_i && idx != FCC_INDEX && idx != FILT_INDEX
      |=> $stable(s.fcc) && $stable(s.filt))
    else $error("Unmapped write changed a register.");

  bypass_a: assert property (
      ack_o && req && we_i && sel_i[0] && idx == FILT_INDEX
      |=> filter_bypass_o == $past(dat_i[7])
          && decimator_input_shift_o == $past(dat_i[6:5]))
    else $error("Filter control outputs mismatch.");

  dev_fields_a: assert property (
      ack_o && req && we_i && sel_i[0] && idx == FCC_INDEX
      |=> rx_dev_exponent_o == $past(dat_i[5:4]) && rx_dev_mantissa_o == $past(dat_i[3:0]))
    else $error("Deviation fields do not follow the write.");

  // Frequency offset averaging.
  afc_enable_a: assert property (
      1'b1
      |=> afc_enable_o == ($past(settle) != 2'h0))
    else $error("Frequency control enable wrong.");

  afc_off_zero_a: assert property (
      settle == 2'h0
      |=> freq_offset_o == '0 && !freq_offset_valid_o && !afc_enable_o)
    else $error("Offset not zero with frequency control off.");

  pair_count_a: assert property (
      settle != 2'h0 && $stable(settle)
      |=> avg_pairs_o == (3'h1 << ($past(settle) - 2'h1)))
    else $error("Averaging length does not follow settling field.");

  one_pair_avg_a: assert property (
      settle == 2'h1 && pair_strobe_i && s.acc == '0 && !(req && we_i)
      |=> freq_offset_valid_o && freq_offset_o == $past(freq_est_i))
    else $error("Single pair average wrong.");

  two_pair_avg_a: assert property (
      settle == 2'h2 && s.pair_cnt == 2'h1 && pair_strobe_i && !(req && ack_o && we_i)
      |=> freq_offset_valid_o)
    else $error("Two pair average not delivered.");

  four_pair_avg_a: assert property (
      settle == 2'h3 && s.pair_cnt == 2'h3 && pair_strobe_i && !(req && ack_o && we_i)
      |=> freq_offset_valid_o)
    else $error("Four pair average not delivered.");

  no_early_valid_a: assert property (
      settle == 2'h3 && s.pair_cnt != 2'h3 && pair_strobe_i
      |=> !freq_offset_valid_o)
    else $error("Average delivered before four pairs.");

  avg_hold_a: assert property (
      settle != 2'h0 && !pair_strobe_i
      |=> $stable(freq_offset_o) && !freq_offset_valid_o)
    else $error("Offset changed without a pair.");

  // Derived outputs follow the registers one cycle later.
  dev_scaled_a: assert property (
      1'b1
      |=> rx_dev_scaled_o == 7'({3'h0, $past(s.fcc[3:0])} << $past(s.fcc[5:4])))
    else $error("Expected deviation scaling wrong.");

  divisor_a: assert property (
      1'b1
      |=> decimation_divisor_o == {1'b0, $past(s.filt[DIV_HI:DIV_LO])} + 6'h01)
    else $error("Decimation divisor wrong.");

  tick_period_a: assert property (
      dec_clk_tick_o && div_age > 6'h28
      |-> tick_gap == decimation_divisor_o - 6'h01)
    else $error("Decimation tick period wrong.");

  tick_gap_a: assert property (
      1'b1
      |-> tick_gap < 6'h20)
    else $error("Decimation tick gap beyond 32 cycles.");

  bandwidth_a: assert property (
      1'b1
      |=> channel_bw_o == BW_WIDTH'(BW_BASE_DHZ / ($past(s.filt[DIV_HI:DIV_LO]) + 1)))
    else $error("Channel bandwidth wrong.");

  // Main scenarios that the bench is expected to reach.
  avg_four_c: cover property (settle == 2'h3 && freq_offset_valid_o);
  two_pair_c: cover property (settle == 2'h2 && freq_offset_valid_o);
  afc_off_c:  cover property (settle == 2'h0 ##1 afc_enable_o == 1'b0);
  div32_c:    cover property (decimation_divisor_o == 6'h20 && dec_clk_tick_o);
  write_c:    cover property (ack_o && we_i && idx == FILT_INDEX);

endmodule : rx_path_cfg

// ===== verification/cfg_host.sv
/*
  Host model: a classic Wishbone master that programs the configuration bank.
  Assumes one clock shared with the bank; a transfer not acked in 16 cycles sets hung.
*/
`timescale 1ns/100ps
module cfg_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      wdat_o
);
  logic hung = 1'b0;

  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hF;
    wdat_o = 32'h00000000;
  end

  // Ack and read data are taken at the rising edge where ack stands; the
  // bank updates its registers by non-blocking assignment, so no race.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    int n;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    wdat_o <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    hung |= (ack_i !== 1'b1);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    @(posedge clk_i);
  endtask : xfer

  // Deviation given in units of baud/24, normalised so the mantissa fits.
  function automatic logic [7:0] fcc_word(input logic [1:0] s, input int dev);
    int x;
    x = 0;
    while (dev >= 16 && x < 3) begin
      dev = dev >> 1;
      x++;
    end
    return {s, x[1:0], dev[3:0]};
  endfunction : fcc_word

  function automatic logic [7:0] filt_word(input logic byp, input logic [4:0] d);
    return {byp, (d <= 5'h01) ? 2'h0 : (d < 5'h18) ? 2'h1 : 2'h2, d};
  endfunction : filt_word
endmodule : cfg_host

// ===== verification/test_afc_and_channel_filter_config.sv
/*
  Self-checking bench for the receive-path configuration bank.
  Assumes the host model drives the bus; the bench feeds the averager itself.
*/
`timescale 1ns/100ps
module test_afc_and_channel_filter_config;
  import rx_path_cfg_pkg::*;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc, stb, we, ack, strobe, afc_en, valid, byp, tick;
  logic [7:0]         adr;
  logic [3:0]         sel, dev_m;
  logic [31:0]        wdat, rdat, q;
  logic signed [11:0] est, offset;
  logic [2:0]         pairs;
  logic [1:0]         dev_x, shift;
  logic [6:0]         scaled;
  logic [5:0]         divisor;
  logic [21:0]        bw;
  int                 n_errors = 0;
  int                 n_compared = 0;

  always #5 clk_i = ~clk_i;

  cfg_host host (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));

  rx_path_cfg uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .pair_strobe_i(strobe), .freq_est_i(est), .afc_enable_o(afc_en), .avg_pairs_o(pairs),
    .freq_offset_o(offset), .freq_offset_valid_o(valid), .rx_dev_exponent_o(dev_x),
    .rx_dev_mantissa_o(dev_m), .rx_dev_scaled_o(scaled), .filter_bypass_o(byp),
    .decimator_input_shift_o(shift), .decimation_divisor_o(divisor),
    .dec_clk_tick_o(tick), .channel_bw_o(bw));

  task automatic tally_and_finish;
    $display("errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    host.xfer(w, a, d, q);
    if (host.hung) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : access

  task automatic check_cfg(input logic [7:0] f, input logic [7:0] g);
    int n;
    @(negedge clk_i);
    check(afc_en, f[7:6] != 2'h0);
    check(pairs, f[7:6] == 2'h0 ? 0 : 1 << (f[7:6] - 1));
    check({dev_x, dev_m}, f[5:0]);
    check(scaled, {3'h0, f[3:0]} << f[5:4]);
    check({byp, shift}, g[7:5]);
    check(divisor, g[4:0] + 6'h01);
    check(bw, BW_BASE_DHZ / (g[4:0] + 1));
    n = 0;
    repeat (4 * (g[4:0] + 1)) begin
      @(negedge clk_i);
      n += tick;
    end
    check(n, 4);
    @(posedge clk_i);
  endtask : check_cfg

  initial begin
    logic [7:0] f, g;
    int         sum;
    strobe = 1'b0;
    est = 12'h000;
    void'($urandom(32'h8A503B25));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    access(1'b0, 8'h3C, 8'h00);
    check(q, 32'h9C);
    access(1'b0, 8'h40, 8'h00);
    check(q, 32'h00);
    access(1'b0, 8'h44, 8'h00);
    check(q, 32'h00);
    check_cfg(8'h9C, 8'h00);
    // The first two passes pin every field at its lowest and highest value.
    for (int i = 0; i < 24; i++) begin
      f = (i < 2) ? {8{i[0]}} : 8'($urandom());
      g = (i < 2) ? {8{i[0]}} : 8'($urandom());
      access(1'b1, 8'h3C, f);
      access(1'b1, 8'h40, g);
      access(1'b1, 8'h44, 8'hFF);
      access(1'b0, 8'h3C, 8'h00);
      check(q, {24'h0, f});
      access(1'b0, 8'h40, 8'h00);
      check(q, {24'h0, g});
      check_cfg(f, g);
    end
    access(1'b1, 8'h3C, host.fcc_word(2'h3, 96));
    access(1'b1, 8'h40, host.filt_word(1'b0, 5'h1D));
    check_cfg(8'hFC, 8'h5D);
    for (int s = 0; s < 4; s++) begin
      access(1'b1, 8'h3C, {s[1:0], 6'h1C});
      sum = 0;
      for (int k = 0; k < ((s == 0) ? 2 : 1 << (s - 1)); k++) begin
        est <= 12'($urandom());
        strobe <= 1'b1;
        @(posedge clk_i);
        sum += est;
      end
      strobe <= 1'b0;
      @(negedge clk_i);
      check(valid, s != 0);
      check(offset, (s == 0) ? 0 : sum >>> (s - 1));
      @(posedge clk_i);
    end
    tally_and_finish();
  end
endmodule : test_afc_and_channel_filter_config
